// >>> rtl/cmv_regs.svh
// Purpose: Offsets, field positions, reset values of the comparator block
// Assumes: 32-bit classic Wishbone, one aligned word per register
// Notes: Definitions only
`ifndef CMV_REGS_SVH
`define CMV_REGS_SVH

// Byte offsets
`define CMV_OFS_CTRL1 8'h00
`define CMV_OFS_CTRL2 8'h04
`define CMV_OFS_CTRL3 8'h08
`define CMV_OFS_STAT 8'h0C
`define CMV_OFS_VREF 8'h10
`define CMV_OFS_IRQ_STATUS 8'h14
`define CMV_OFS_IRQ_MASK 8'h18

// comparator_control fields
`define CMV_CTL_ENABLE 15
`define CMV_CTL_PIN_OE 14
`define CMV_CTL_POLARITY 13
`define CMV_CTL_EVENT 9
`define CMV_CTL_OUTPUT 8
`define CMV_CTL_EVPOL_HI 7
`define CMV_CTL_EVPOL_LO 6
`define CMV_CTL_REF_SEL 4
`define CMV_CTL_CH_HI 1
`define CMV_CTL_CH_LO 0
`define CMV_CTL_WMASK 16'hE0D3

// comparator_status fields
`define CMV_STA_IDLE_STOP 15
`define CMV_STA_EVT_LO 8
`define CMV_STA_OUT_LO 0
`define CMV_STA_WMASK 16'h8000

// reference_voltage_control fields
`define CMV_VRF_ENABLE 7
`define CMV_VRF_PIN_OUT 6
`define CMV_VRF_RANGE 5
`define CMV_VRF_SOURCE 4
`define CMV_VRF_LEVEL_HI 3
`define CMV_VRF_WMASK 16'h00FF

// Reference fraction in 1/96 of the span: lcm of 24 and 32
`define CMV_FRAC_FINE_STEP 7'h04
`define CMV_FRAC_COARSE_STEP 7'h03
`define CMV_FRAC_COARSE_BASE 7'h18

`define CMV_RST_WORD 16'h0000
`define CMV_RST_FRAC 7'h00

`endif

// >>> rtl/cmv_pkg.sv
// Purpose: Types shared by the comparator control files
// Assumes: Constants live in cmv_regs.svh
// Notes: Types only
package cmv_pkg;
  typedef logic [15:0] cmv_word_t;
  typedef enum logic [7:0] {
    CMV_SEL_NONE = 8'h01,
    CMV_SEL_CTRL = 8'h02,
    CMV_SEL_STAT = 8'h04,
    CMV_SEL_VREF = 8'h08,
    CMV_SEL_IST = 8'h10,
    CMV_SEL_IMSK = 8'h20
  } cmv_sel_t;
  typedef enum logic [1:0] {
    CMV_EV_OFF = 2'b00,
    CMV_EV_RISE = 2'b01,
    CMV_EV_FALL = 2'b10,
    CMV_EV_ANY = 2'b11
  } cmv_evpol_t;
endpackage

// >>> rtl/cmv_event.sv
// Purpose: One comparator: input synchroniser, polarity, event detector
// Assumes: raw_in comes from the analog comparator, asynchronous
// Notes: Edges are judged on the raw comparator result
`timescale 1ns/1ns
module cmv_event
  import cmv_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Comparator
  input wire logic raw_in,
  input wire logic enable,
  input wire logic invert,
  input wire cmv_evpol_t evpol,
  input wire logic event_flag,
  // Results
  output logic out_q,
  output logic trig_q
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic hit;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always_comb
  begin
    unique case (evpol)
      CMV_EV_OFF: hit = 1'b0;
      CMV_EV_RISE: hit = sync2_q & ~prev_q;
      CMV_EV_FALL: hit = ~sync2_q & prev_q;
      CMV_EV_ANY: hit = sync2_q ^ prev_q;
    endcase
  end

  // A disabled comparator reads as zero and raises nothing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= 1'b0;
      trig_q <= 1'b0;
    end
    else
    begin
      out_q <= enable & (sync2_q ^ invert);
      trig_q <= enable & hit & ~event_flag;
    end
  end
endmodule

// >>> rtl/cmv_top.sv
// Purpose: Register bank for three comparators and their voltage reference
// Assumes: Classic Wishbone slave, 32-bit data, MCLK at 100 MHz
// Notes: Analog parts sit outside; this block drives their selects
`timescale 1ns/1ns
`include "cmv_regs.svh"
module cmv_top
  import cmv_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Comparators
  input wire logic [2:0] CMP_RAW,
  input wire logic IDLE_MODE,
  output logic [2:0] CMP_ENABLE,
  output logic [2:0] CMP_NONINV_REF,
  output logic [11:0] CMP_INV_SEL,
  output logic [2:0] CMP_OUT_PIN,
  output logic [2:0] CMP_OUT_OE,
  output logic [2:0] CMP_TRIGGER,
  // Voltage reference
  output logic VREF_POWER,
  output logic VREF_PIN_DRIVE,
  output logic VREF_RANGE,
  output logic VREF_SOURCE,
  output logic [3:0] VREF_LEVEL,
  output logic [6:0] VREF_FRACTION,
  // Interrupt
  output logic IRQ
);

  // Merge a write into a stored word under byte lanes and a writable mask
  function automatic cmv_word_t merge(input cmv_word_t old_v,
                                      input cmv_word_t new_v,
                                      input logic [1:0] sel,
                                      input cmv_word_t wmask);
    cmv_word_t lanes;
    lanes = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
    merge = (old_v & ~lanes) | (new_v & lanes);
  endfunction

  // Reference as a fraction of the span, in 1/96 units
  function automatic logic [6:0] vref_frac(input logic range,
                                           input logic [3:0] level);
    logic [6:0] lv;
    lv = {3'b000, level};
    if (range)
      vref_frac = 7'(lv * `CMV_FRAC_FINE_STEP);
    else
      vref_frac = 7'(`CMV_FRAC_COARSE_BASE + lv * `CMV_FRAC_COARSE_STEP);
  endfunction

  // One-hot inverting input select: B, C, D, half band-gap
  function automatic logic [3:0] ch_onehot(input logic [1:0] ch);
    ch_onehot = 4'(4'h1 << ch);
  endfunction

  cmv_word_t ctrl_q [3];
  logic [2:0] evt_q;
  logic [2:0] cmp_out;
  logic [2:0] cmp_trig;
  logic idle_stop_q;
  logic [7:0] vref_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_mask_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic wr;
  cmv_sel_t sel;
  logic [1:0] ctrl_idx;
  cmv_word_t wdat;
  cmv_word_t stat_word;
  cmv_word_t rd_word;

  assign req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr = req & WB_WE_I;
  assign wdat = WB_DAT_I[15:0];

  always_comb
  begin
    sel = CMV_SEL_NONE;
    ctrl_idx = 2'd0;
    unique case (WB_ADR_I)
      `CMV_OFS_CTRL1:
      begin
        sel = CMV_SEL_CTRL;
        ctrl_idx = 2'd0;
      end
      `CMV_OFS_CTRL2:
      begin
        sel = CMV_SEL_CTRL;
        ctrl_idx = 2'd1;
      end
      `CMV_OFS_CTRL3:
      begin
        sel = CMV_SEL_CTRL;
        ctrl_idx = 2'd2;
      end
      `CMV_OFS_STAT: sel = CMV_SEL_STAT;
      `CMV_OFS_VREF: sel = CMV_SEL_VREF;
      `CMV_OFS_IRQ_STATUS: sel = CMV_SEL_IST;
      `CMV_OFS_IRQ_MASK: sel = CMV_SEL_IMSK;
      default: sel = CMV_SEL_NONE;
    endcase
  end

  // Per-comparator detectors
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cmp
      cmv_event u_event (
        .clk(MCLK),
        .rst_n(RESET_N),
        .raw_in(CMP_RAW[gi]),
        .enable(ctrl_q[gi][`CMV_CTL_ENABLE]),
        .invert(ctrl_q[gi][`CMV_CTL_POLARITY]),
        .evpol(cmv_evpol_t'(
          ctrl_q[gi][`CMV_CTL_EVPOL_HI:`CMV_CTL_EVPOL_LO])),
        .event_flag(evt_q[gi]),
        .out_q(cmp_out[gi]),
        .trig_q(cmp_trig[gi])
      );
    end
  endgenerate

  // Control words; read-only and unimplemented positions never stored
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < 3; i++)
        ctrl_q[i] <= `CMV_RST_WORD;
    end
    else if (wr && sel == CMV_SEL_CTRL)
    begin
      ctrl_q[ctrl_idx] <= merge(ctrl_q[ctrl_idx], wdat, WB_SEL_I[1:0],
                                `CMV_CTL_WMASK);
    end
  end

  // Event flags: software may write them, a new event wins over a clear
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      evt_q <= 3'b000;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (cmp_trig[i])
          evt_q[i] <= 1'b1;
        else if (wr && sel == CMV_SEL_CTRL && ctrl_idx == 2'(i)
                 && WB_SEL_I[1])
          evt_q[i] <= wdat[`CMV_CTL_EVENT];
      end
    end
  end

  // Status word holds only the idle stop bit as storage
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      idle_stop_q <= 1'b0;
    else if (wr && sel == CMV_SEL_STAT && WB_SEL_I[1])
      idle_stop_q <= wdat[`CMV_STA_IDLE_STOP];
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      vref_q <= 8'h00;
    else if (wr && sel == CMV_SEL_VREF)
      vref_q <= 8'(merge({8'h00, vref_q}, wdat, WB_SEL_I[1:0],
                         `CMV_VRF_WMASK));
  end

  // Interrupt status: write one to clear, a new event wins
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      irq_st_q <= 3'b000;
    else if (wr && sel == CMV_SEL_IST && WB_SEL_I[0])
      irq_st_q <= (irq_st_q & ~wdat[2:0]) | cmp_trig;
    else
      irq_st_q <= irq_st_q | cmp_trig;
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      irq_mask_q <= 3'b000;
    else if (wr && sel == CMV_SEL_IMSK && WB_SEL_I[0])
      irq_mask_q <= wdat[2:0];
  end

  // Comparators keep running in idle; only the request line is held off
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      IRQ <= 1'b0;
    else
      IRQ <= (|(irq_st_q & irq_mask_q)) & ~(idle_stop_q & IDLE_MODE);
  end

  // Status word: mirrors are live, bits 14..11 and 7..3 read zero
  always_comb
  begin
    stat_word = `CMV_RST_WORD;
    stat_word[`CMV_STA_IDLE_STOP] = idle_stop_q;
    stat_word[`CMV_STA_EVT_LO +: 3] = evt_q;
    stat_word[`CMV_STA_OUT_LO +: 3] = cmp_out;
  end

  always_comb
  begin
    rd_word = `CMV_RST_WORD;
    unique case (sel)
      CMV_SEL_CTRL:
      begin
        rd_word = ctrl_q[ctrl_idx];
        rd_word[`CMV_CTL_EVENT] = evt_q[ctrl_idx];
        rd_word[`CMV_CTL_OUTPUT] = cmp_out[ctrl_idx];
      end
      CMV_SEL_STAT: rd_word = stat_word;
      CMV_SEL_VREF: rd_word = {8'h00, vref_q};
      CMV_SEL_IST: rd_word = {13'h0000, irq_st_q};
      CMV_SEL_IMSK: rd_word = {13'h0000, irq_mask_q};
      CMV_SEL_NONE: rd_word = `CMV_RST_WORD;
    endcase
  end

  // Single-cycle answer; unmapped addresses ack with zero data
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      if (req && !WB_WE_I)
        dat_q <= {16'h0000, rd_word};
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // Analog steering, registered so every pin comes from a flip-flop
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      CMP_ENABLE <= 3'b000;
      CMP_NONINV_REF <= 3'b000;
      CMP_INV_SEL <= 12'h000;
      CMP_OUT_PIN <= 3'b000;
      CMP_OUT_OE <= 3'b000;
      CMP_TRIGGER <= 3'b000;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        CMP_ENABLE[i] <= ctrl_q[i][`CMV_CTL_ENABLE];
        CMP_NONINV_REF[i] <= ctrl_q[i][`CMV_CTL_REF_SEL];
        CMP_INV_SEL[i*4 +: 4] <= ch_onehot(
          ctrl_q[i][`CMV_CTL_CH_HI:`CMV_CTL_CH_LO]);
        CMP_OUT_OE[i] <= ctrl_q[i][`CMV_CTL_PIN_OE];
        CMP_OUT_PIN[i] <= ctrl_q[i][`CMV_CTL_PIN_OE] & cmp_out[i];
      end
      CMP_TRIGGER <= cmp_trig;
    end
  end

  // Reference controls; settling after a change is left to software
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      VREF_POWER <= 1'b0;
      VREF_PIN_DRIVE <= 1'b0;
      VREF_RANGE <= 1'b0;
      VREF_SOURCE <= 1'b0;
      VREF_LEVEL <= 4'h0;
      VREF_FRACTION <= `CMV_RST_FRAC;
    end
    else
    begin
      VREF_POWER <= vref_q[`CMV_VRF_ENABLE];
      VREF_PIN_DRIVE <= vref_q[`CMV_VRF_PIN_OUT];
      VREF_RANGE <= vref_q[`CMV_VRF_RANGE];
      VREF_SOURCE <= vref_q[`CMV_VRF_SOURCE];
      VREF_LEVEL <= vref_q[`CMV_VRF_LEVEL_HI:0];
      VREF_FRACTION <= vref_frac(vref_q[`CMV_VRF_RANGE],
                                 vref_q[`CMV_VRF_LEVEL_HI:0]);
    end
  end

endmodule

// >>> sim/cmv_top_asserts.sv
// Purpose: Port assertions for the comparator register bank
// Assumes: Bound to cmv_top, single MCLK domain
// Notes: Fraction reads zero out of reset, so coarse check waits
`timescale 1ns/1ns
`include "cmv_regs.svh"
module cmv_top_asserts
  import cmv_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // Comparators and reference
  input wire logic [2:0] CMP_ENABLE,
  input wire logic [11:0] CMP_INV_SEL,
  input wire logic [2:0] CMP_TRIGGER,
  input wire logic VREF_RANGE,
  input wire logic [3:0] VREF_LEVEL,
  input wire logic [6:0] VREF_FRACTION
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire logic st_rd = WB_ACK_O && !WB_WE_I && WB_ADR_I == `CMV_OFS_STAT;

  a_ack_next: assert property (req |=> WB_ACK_O)
    else $error("ack missing after request");
  a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(req))
    else $error("ack without request");
  a_stat_gaps: assert property (st_rd |->
    WB_DAT_O[14:11] == 4'h0 && WB_DAT_O[7:3] == 5'h00)
    else $error("status gap bits set");
  // Level, range and fraction load on the same edge, so no settling wait
  a_frac_fine: assert property (VREF_RANGE |->
    VREF_FRACTION == {1'b0, VREF_LEVEL, 2'b00})
    else $error("fine fraction wrong");
  a_frac_coarse: assert property (!VREF_RANGE && $past(RESET_N) |->
    VREF_FRACTION == 7'h18 + 7'h03 * VREF_LEVEL)
    else $error("coarse fraction wrong");
  a_inv_onehot: assert property ($onehot0(CMP_INV_SEL[3:0]) &&
    $onehot0(CMP_INV_SEL[7:4]) && $onehot0(CMP_INV_SEL[11:8]))
    else $error("channel select not one-hot");
  a_trig_gap: assert property (CMP_TRIGGER[2] |=>
    !CMP_TRIGGER[2] [*3])
    else $error("trigger repeated");
  a_trig_enabled: assert property (
    (CMP_TRIGGER & ~$past(CMP_ENABLE)) == 3'h0)
    else $error("trigger while disabled");
  c_write: cover property (WB_ACK_O && WB_WE_I);
  c_stat: cover property (st_rd);
  c_trig: cover property (CMP_TRIGGER[2]);
endmodule
bind cmv_top cmv_top_asserts u_chk (.MCLK(MCLK), .RESET_N(RESET_N),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .CMP_ENABLE(CMP_ENABLE), .CMP_INV_SEL(CMP_INV_SEL),
  .CMP_TRIGGER(CMP_TRIGGER), .VREF_RANGE(VREF_RANGE),
  .VREF_LEVEL(VREF_LEVEL), .VREF_FRACTION(VREF_FRACTION));

// >>> sim/cmv_top_tb.sv
// Purpose: Register and event tests for the comparator bank
// Assumes: Outputs settle within two clocks of a bus write
// Notes: Only comparator 3 carries event traffic
`timescale 1ns/1ns
`include "cmv_regs.svh"
module cmv_top_tb;
  logic mclk, rst_n, cyc, stb, we, idle, ack, irq, pwr, pin, rng, src;
  logic [7:0] adr;
  logic [31:0] dat, dat_o;
  logic [2:0] raw, trig, cen, nref, oe, opin;
  logic [3:0] lvl, lanes;
  logic [6:0] frac;
  logic [11:0] isel;
  logic [15:0] rdq, w;
  int fail_count, tests_run, trig_n;

  cmv_top dut (.MCLK(mclk), .RESET_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(lanes),
    .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CMP_RAW(raw),
    .IDLE_MODE(idle), .CMP_ENABLE(cen), .CMP_NONINV_REF(nref),
    .CMP_INV_SEL(isel), .CMP_OUT_PIN(opin), .CMP_OUT_OE(oe),
    .CMP_TRIGGER(trig), .VREF_POWER(pwr), .VREF_PIN_DRIVE(pin),
    .VREF_RANGE(rng), .VREF_SOURCE(src), .VREF_LEVEL(lvl),
    .VREF_FRACTION(frac), .IRQ(irq));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Counted on the falling edge so the pulse has settled
  always @(negedge mclk)
    if (trig[2] === 1'b1)
      trig_n <= trig_n + 1;

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("BAD %0t got %h want %h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic wb(input logic wr, input logic [7:0] a,
                    input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= {16'h0000, d};
    // Ack and read data are taken at the rising edge that samples ack
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    chk(ack, 1'b1);
    rdq = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    chk(rdq, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    {cyc, stb, we, idle, adr, dat, raw} = '0;
    lanes = 4'h3;
    {fail_count, tests_run, trig_n} = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(8'(4 * i), 16'h0000);
    wb(1'b1, 8'h1C, 16'hFFFF);
    rd(8'h1C, 16'h0000);
    wb(1'b1, `CMV_OFS_CTRL1, 16'h1D2C);
    rd(`CMV_OFS_CTRL1, 16'h0000);
    // Comparator 2 stays disabled with any-change events armed
    for (int c = 0; c < 4; c++)
    begin
      w = 16'(c) | (c[0] ? 16'h0010 : 16'h0000) | 16'h00C0;
      wb(1'b1, `CMV_OFS_CTRL2, w);
      wt(2);
      chk(nref[1], c[0]);
      chk(isel[7:4], 4'h1 << c);
      rd(`CMV_OFS_CTRL2, w);
    end
    // Sweep every level in both ranges, toggling the other controls
    for (int i = 0; i < 32; i++)
    begin
      w = {8'h00, ~i[0], i[0], i[4], i[1], i[3:0]};
      wb(1'b1, `CMV_OFS_VREF, w | 16'hA500);
      wt(2);
      chk({pwr, pin, rng, src, lvl}, w);
      chk(frac, i[4] ? {1'b0, i[3:0], 2'b00} : 7'h18 + 7'h03 * i[3:0]);
      rd(`CMV_OFS_VREF, w);
    end
    wb(1'b1, `CMV_OFS_STAT, 16'hFFFF);
    rd(`CMV_OFS_STAT, 16'h8000);
    // With only the high lane enabled the level byte must survive
    lanes <= 4'h2;
    wb(1'b1, `CMV_OFS_VREF, 16'h0000);
    rd(`CMV_OFS_VREF, 16'h007F);
    lanes <= 4'h3;
    wb(1'b1, `CMV_OFS_CTRL3, 16'hC040);
    wb(1'b1, `CMV_OFS_IRQ_MASK, 16'h0004);
    // The edge on disabled comparator 2 must raise nothing
    @(posedge mclk) raw <= 3'b110;
    wt(12);
    chk(trig_n, 1);
    chk(irq, 1'b1);
    chk({cen, oe, opin}, 9'h124);
    rd(`CMV_OFS_STAT, 16'h8404);
    rd(`CMV_OFS_CTRL3, 16'hC340);
    @(posedge mclk) raw <= 3'b000;
    wt(8);
    @(posedge mclk) raw <= 3'b100;
    wt(12);
    chk(trig_n, 1);
    @(posedge mclk) idle <= 1'b1;
    wt(3);
    chk(irq, 1'b0);
    @(posedge mclk) idle <= 1'b0;
    wt(3);
    chk(irq, 1'b1);
    wb(1'b1, `CMV_OFS_IRQ_MASK, 16'h0000);
    wt(2);
    chk(irq, 1'b0);
    wb(1'b1, `CMV_OFS_IRQ_MASK, 16'h0004);
    rd(`CMV_OFS_IRQ_STATUS, 16'h0004);
    wb(1'b1, `CMV_OFS_IRQ_STATUS, 16'h0004);
    wt(2);
    chk(irq, 1'b0);
    wb(1'b1, `CMV_OFS_CTRL3, 16'hC040);
    rd(`CMV_OFS_STAT, 16'h8004);
    @(posedge mclk) raw <= 3'b000;
    wt(8);
    @(posedge mclk) raw <= 3'b100;
    wt(12);
    chk(trig_n, 2);
    report_and_stop();
  end
endmodule
